// [core/qr_pwm_trigger_and_fault_control.sv]
// valley trigger, on-time gate pulse and protection core
`timescale 1ns/10ps
`default_nettype none
`include "qr_pwm_map.svh"

// Overview of operation
// - gate high for loop-chosen fixed on-time
// - blanking interval starts at each gate rise
// - valleys during blanking never start pulses
// - first valley after blanking starts pulse
// - blank valleys, none after: fallback 5us
// - starter launches pulse 130us after rise
// - aux over-voltage forces gate low
// - restart after over-voltage, retrip if present
// - sense over-threshold on 2 pulses in a row stops gate
// - sense shutdown resumes after retry hold
// - hysteretic supply lockout enables and disables
// - supply over-voltage stops, restarts when normal
// - thermal trip holds off until cooled
// - thermal with lockout cycles in hiccup
module qr_pwm_trigger_and_fault_control
  import qr_pwm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_valley,
  input wire logic i_aux_over,
  input wire logic i_sense_over,
  input wire logic i_supply_above_on,
  input wire logic i_supply_below_off,
  input wire logic i_supply_over,
  input wire logic i_thermal_trip,
  input wire logic i_thermal_cooled,
  input wire logic [11:0] i_on_time,
  output logic o_gate_drive_out,
  output logic o_enabled,
  output logic o_output_ovp,
  output logic o_sense_shutdown,
  output logic o_supply_ovp,
  output logic o_thermal_shutdown
);

  // ============================================================
  // constants at counter width
  localparam count_t blank_cyc = count_t'(`MIN_PERIOD_BLANK_CYC);
  localparam count_t fallback_end = count_t'(`MIN_PERIOD_BLANK_CYC + `VALLEY_FALLBACK_CYC);
  localparam count_t starter_cyc = count_t'(`STARTER_INTERVAL_CYC);
  localparam count_t retry_cyc = count_t'(`FAULT_RETRY_CYC);
  localparam logic [1:0] sense_limit = 2'(`SENSE_SD_PULSES);

  function automatic count_t sat_inc(input count_t v);
    sat_inc = (v == 12'hFFF) ? v : v + 12'h001;
  endfunction

  core_state_s st;
  core_state_s next_st;

  // ============================================================
  // combinational next state
  always_comb
  begin
    logic [7:0] syn;
    logic valley_edge;
    logic halt;
    logic fire;
    count_t on_len;
    valley_edge = 1'b0;
    halt = 1'b0;
    fire = 1'b0;
    on_len = 12'h001;
    next_st = st;
    syn = st.s2;
    next_st.s1 = {i_thermal_cooled, i_thermal_trip, i_supply_over, i_supply_below_off,
                  i_supply_above_on, i_sense_over, i_aux_over, i_valley};
    next_st.s2 = st.s1;
    next_st.valley_d = syn[`SYN_VALLEY];
    valley_edge = syn[`SYN_VALLEY] & ~st.valley_d;
    // a zero on-time request still gives one cycle so the sequence never stalls
    on_len = (i_on_time == 12'h000) ? 12'h001 : i_on_time;

    // hysteretic lockout
    if (syn[`SYN_SUPPLY_OFF])
      next_st.enabled = 1'b0;
    else if (syn[`SYN_SUPPLY_ON])
      next_st.enabled = 1'b1;

    // supply over-voltage follows the comparator, so recovery is automatic
    next_st.supply_ovp = syn[`SYN_SUPPLY_OVP];

    // thermal latch survives lockout so the supply keeps hiccuping
    if (syn[`SYN_THERM_TRIP])
      next_st.thermal = 1'b1;
    else if (syn[`SYN_THERM_CLEAR])
      next_st.thermal = 1'b0;

    // retry hold shared by output over-voltage and sense shutdown
    if (st.output_ovp || st.sense_sd)
    begin
      if (st.hold_cnt >= retry_cyc - 12'h001)
      begin
        // the aux sample is a level: still high at retry means shut down again
        next_st.output_ovp = st.output_ovp & syn[`SYN_AUX_OVP];
        next_st.sense_sd = 1'b0;
        next_st.hold_cnt = '0;
      end
      else
        next_st.hold_cnt = sat_inc(st.hold_cnt);
    end
    else
      next_st.hold_cnt = '0;

    if (syn[`SYN_AUX_OVP] && st.state != st_halted)
    begin
      next_st.output_ovp = 1'b1;
      next_st.hold_cnt = '0;
    end

    halt = ~st.enabled | st.thermal | st.supply_ovp | st.output_ovp | st.sense_sd
           | syn[`SYN_AUX_OVP];
    fire = 1'b0;
    next_st.period_cnt = sat_inc(st.period_cnt);

    case (st.state)
      st_halted:
      begin
        next_st.gate = 1'b0;
        next_st.sense_pulses = '0;
        if (!halt)
          fire = 1'b1;
      end
      st_on:
      begin
        if (syn[`SYN_SENSE_SD])
          next_st.sense_this_pulse = 1'b1;
        if (st.on_cnt >= on_len - 12'h001)
        begin
          next_st.gate = 1'b0;
          next_st.state = st_off;
        end
        else
          next_st.on_cnt = sat_inc(st.on_cnt);
      end
      st_off:
      begin
        if (st.period_cnt < blank_cyc)
        begin
          if (valley_edge)
            next_st.valley_seen = 1'b1;
        end
        else if (valley_edge)
          fire = 1'b1;
        else if (st.valley_seen && st.period_cnt >= fallback_end - 12'h001)
          fire = 1'b1;
        if (st.period_cnt >= starter_cyc - 12'h001)
          fire = 1'b1;
      end
      default:
      begin
        next_st.state = st_halted;
        next_st.gate = 1'b0;
      end
    endcase

    // count pulses that crossed the sense threshold back to back
    if (fire && st.state == st_off)
    begin
      if (st.sense_this_pulse)
      begin
        if (st.sense_pulses >= sense_limit - 2'd1)
        begin
          next_st.sense_sd = 1'b1;
          next_st.hold_cnt = '0;
          fire = 1'b0;
          next_st.state = st_halted;
        end
        next_st.sense_pulses = st.sense_pulses + 2'd1;
      end
      else
        next_st.sense_pulses = '0;
    end

    if (fire)
    begin
      next_st.state = st_on;
      next_st.gate = 1'b1;
      next_st.period_cnt = '0;
      next_st.on_cnt = '0;
      next_st.valley_seen = 1'b0;
      next_st.sense_this_pulse = 1'b0;
    end

    // protection overrides any pulse in flight
    if (halt)
    begin
      next_st.state = st_halted;
      next_st.gate = 1'b0;
      next_st.period_cnt = '0;
      next_st.on_cnt = '0;
      next_st.valley_seen = 1'b0;
      next_st.sense_this_pulse = 1'b0;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.state <= st_halted;
    end
    else
      st <= next_st;
  end

  assign o_gate_drive_out = st.gate;
  assign o_enabled = st.enabled;
  assign o_output_ovp = st.output_ovp;
  assign o_sense_shutdown = st.sense_sd;
  assign o_supply_ovp = st.supply_ovp;
  assign o_thermal_shutdown = st.thermal;

endmodule
`default_nettype wire

// [dv/qr_pwm_partner.sv]
// far-side model: valley comparator timed from the gate fall
`timescale 1ns/10ps
`default_nettype none
module qr_pwm_partner(
  input wire logic i_clock,
  input wire logic i_gate,
  input wire logic [1:0] i_mode,
  output var logic o_valley
);
  int n = 0;
  initial o_valley = 1'b0;
  // mode 1 rings inside the blank, mode 2 after it, mode 0 never
  always @(posedge i_clock)
  begin
    n <= i_gate ? 0 : n + 1;
    o_valley <= #1 (i_mode == 2'h1 && n inside {[40:43]}) ||
      (i_mode == 2'h2 && n inside {[200:203]});
  end
endmodule
`default_nettype wire

// [dv/qr_pwm_properties.sv]
// port checker for the qr trigger and fault core
`timescale 1ns/10ps
`default_nettype none
module qr_pwm_checker(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_aux_over,
  input wire logic i_supply_above_on,
  input wire logic i_supply_below_off,
  input wire logic i_supply_over,
  input wire logic i_thermal_cooled,
  input wire logic [11:0] i_on_time,
  input wire logic o_gate_drive_out,
  input wire logic o_enabled,
  input wire logic o_output_ovp,
  input wire logic o_sense_shutdown,
  input wire logic o_supply_ovp,
  input wire logic o_thermal_shutdown
);
  logic hd;
  logic gd_d;
  logic [11:0] since;
  logic [11:0] hi;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  assign hd = !o_enabled || o_output_ovp || o_sense_shutdown || o_supply_ovp
    || o_thermal_shutdown;
  // since saturates on a halt: pulses right after a release are not period-checked
  always_ff @(posedge i_clock or posedge i_rst)
    if (i_rst)
    begin
      gd_d <= 1'b0;
      since <= 12'hFFF;
      hi <= 12'h000;
    end
    else
    begin
      gd_d <= o_gate_drive_out;
      since <= hd ? 12'hFFF : (o_gate_drive_out && !gd_d) ? 12'h000 :
        (since == 12'hFFF ? since : since + 12'h001);
      hi <= o_gate_drive_out ? hi + 12'h001 : 12'h000;
    end
  sequence s_held;
    hd ##1 hd;
  endsequence
  sequence s_aux;
    i_aux_over [*4] ##0 (o_enabled && !o_supply_ovp && !o_thermal_shutdown);
  endsequence
  // the length is decided on the last high cycle, so the on-time of that cycle counts
  AST_ON_TIME: assert property ($fell(o_gate_drive_out) && !hd
    |-> hi == ($past(i_on_time) == 12'h000 ? 12'h001 : $past(i_on_time)))
    else $error("bad on-time");
  AST_BLANK: assert property ($rose(o_gate_drive_out) && since != 12'hFFF
    |-> since >= 12'h0A9) else $error("pulse inside blank");
  AST_STARTER: assert property ($rose(o_gate_drive_out) && since != 12'hFFF
    |-> since <= 12'hA27) else $error("starter late");
  AST_HALT_LOW: assert property (s_held |-> !o_gate_drive_out)
    else $error("gate high while halted");
  AST_ENABLE: assert property ($rose(i_supply_above_on) && !i_supply_below_off
    |-> ##[2:4] o_enabled) else $error("enable late");
  AST_OVP: assert property (s_aux ##0 !o_sense_shutdown
    |-> ##[0:3] o_output_ovp) else $error("ovp missed");
  AST_SUPPLY: assert property (i_supply_over [*5] |-> o_supply_ovp)
    else $error("supply ovp missed");
  AST_THERM_HOLD: assert property (!i_thermal_cooled [*3] ##0 o_thermal_shutdown
    |=> o_thermal_shutdown) else $error("thermal released early");
endmodule
bind qr_pwm_trigger_and_fault_control qr_pwm_checker chk_u (.*);
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the qr trigger and fault core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clock, i_rst, i_valley, i_aux_over, i_sense_over, i_supply_above_on;
  logic i_supply_below_off, i_supply_over, i_thermal_trip, i_thermal_cooled;
  logic [11:0] i_on_time;
  logic o_gate_drive_out, o_enabled, o_output_ovp;
  logic o_sense_shutdown, o_supply_ovp, o_thermal_shutdown;
  logic [1:0] mode = 2'h0;
  int errors = 0;
  int comparisons = 0;
  int k;
  qr_pwm_trigger_and_fault_control dut_u (.*);
  qr_pwm_partner far_u (.i_clock(i_clock), .i_gate(o_gate_drive_out), .i_mode(mode),
    .o_valley(i_valley));
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // cycles until the next low-to-high gate edge, bounded
  task automatic rise(output int c);
    logic p;
    c = 0;
    p = 1'b1;
    while (c < 4000 && !(o_gate_drive_out === 1'b1 && !p))
    begin
      p = o_gate_drive_out;
      cyc(1);
      c++;
    end
  endtask
  // faults are raised with the gate low so no pulse is cut short
  task automatic quiet;
    rise(k);
    cyc(20);
  endtask
  task automatic t_timing;
    for (int m = 0; m < 3; m++)
    begin
      mode = 2'(m);
      rise(k);
      rise(k);
      if (m == 2)
        chk("valley start", 1, k > 200 && k < 225);
      else
        chk("period", m == 0 ? 2600 : 270, k);
    end
    for (int t = 0; t < 2; t++)
    begin
      rise(k);
      for (k = 0; o_gate_drive_out === 1'b1 && k < 99; k++)
        cyc(1);
      chk("on time", t ? 1 : 10, k);
      i_on_time = t ? 12'h00A : 12'h000;
    end
  endtask
  task automatic t_ovp;
    mode = 2'h1;
    quiet;
    i_aux_over = 1'b1;
    cyc(6);
    chk("ovp", 1, o_output_ovp);
    cyc(2800);
    chk("ovp retrip", 1, o_output_ovp);
    i_aux_over = 1'b0;
    rise(k);
    chk("ovp restart", 1, k < 2700);
  endtask
  task automatic t_sense;
    i_sense_over = 1'b1;
    cyc(900);
    chk("sense stop", 1, o_sense_shutdown);
    i_sense_over = 1'b0;
    rise(k);
    chk("sense resume", 1, k < 2700);
  endtask
  task automatic t_supply;
    quiet;
    i_supply_over = 1'b1;
    // a fallback pulse would be due within this span if nothing held the gate
    for (k = 0; k < 300 && o_gate_drive_out !== 1'b1; k++)
      cyc(1);
    chk("gate held low", 300, k);
    chk("supply ovp", 1, o_supply_ovp);
    i_supply_over = 1'b0;
    rise(k);
    chk("vdd restart", 1, k < 8);
  endtask
  task automatic t_thermal;
    quiet;
    i_thermal_trip = 1'b1;
    cyc(6);
    i_thermal_trip = 1'b0;
    i_supply_below_off = 1'b1;
    cyc(20);
    chk("lockout", 0, o_enabled);
    i_supply_below_off = 1'b0;
    cyc(20);
    chk("otp held", 1, o_thermal_shutdown);
    i_thermal_cooled = 1'b1;
    rise(k);
    chk("otp restart", 1, k < 10);
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial
  begin
    cyc(60000);
    errors++;
    final_report;
  end
  initial
  begin
    i_rst = 1'b1;
    {i_aux_over, i_sense_over, i_supply_above_on, i_supply_below_off} = 4'h0;
    {i_supply_over, i_thermal_trip, i_thermal_cooled} = 3'h0;
    i_on_time = 12'h00A;
    cyc(16);
    i_rst = 1'b0;
    cyc(2);
    i_supply_above_on = 1'b1;
    t_timing;
    t_ovp;
    t_sense;
    t_supply;
    t_thermal;
    final_report;
  end
endmodule
`default_nettype wire

// [include/qr_pwm_map.svh]
// timing constants and counts for the qr trigger and fault core
`ifndef QR_PWM_MAP_SVH
`define QR_PWM_MAP_SVH

// ============================================================
// clock
`define CLOCK_PERIOD_NS 50

// ============================================================
// times in ns, figures as printed
`define MIN_PERIOD_BLANK_NS 8500
`define VALLEY_FALLBACK_NS 5000
`define STARTER_INTERVAL_NS 130000
`define FAULT_RETRY_NS 130000

// ============================================================
// cycle counts, least times rounded up
`define MIN_PERIOD_BLANK_CYC \
  ((`MIN_PERIOD_BLANK_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define VALLEY_FALLBACK_CYC \
  ((`VALLEY_FALLBACK_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STARTER_INTERVAL_CYC \
  ((`STARTER_INTERVAL_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define FAULT_RETRY_CYC \
  ((`FAULT_RETRY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// ============================================================
// sense shutdown: consecutive over-threshold pulses before stop
`define SENSE_SD_PULSES 2

// ============================================================
// synchroniser bit positions
`define SYN_VALLEY 0
`define SYN_AUX_OVP 1
`define SYN_SENSE_SD 2
`define SYN_SUPPLY_ON 3
`define SYN_SUPPLY_OFF 4
`define SYN_SUPPLY_OVP 5
`define SYN_THERM_TRIP 6
`define SYN_THERM_CLEAR 7
`define SYN_WIDTH 8

`endif

// [include/qr_pwm_pkg.sv]
// types for the qr trigger and fault core
package qr_pwm_pkg;

  typedef enum logic [1:0] {
    st_halted,
    st_on,
    st_off
  } gate_state_e;

  typedef logic [11:0] count_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic valley_d;
    gate_state_e state;
    count_t period_cnt;
    count_t on_cnt;
    count_t hold_cnt;
    logic valley_seen;
    logic sense_this_pulse;
    logic [1:0] sense_pulses;
    logic enabled;
    logic thermal;
    logic output_ovp;
    logic sense_sd;
    logic supply_ovp;
    logic gate;
  } core_state_s;

endpackage
